/* File: shared/prio_flood_pkg.sv */
package prio_flood_pkg;

    localparam int unsigned ADDR_W = 16;

    // Register indices; the byte address is four times the index
    localparam logic [15:0] LED_CTRL_IDX = 16'h040A;
    localparam logic [15:0] TAG_MAP_IDX = 16'h0410;
    localparam logic [15:0] UNK_FWD_IDX = 16'h0412;
    localparam logic [15:0] MODE_IDX = 16'h0414;
    localparam logic [15:0] LED_CTRL_ADDR = 16'(LED_CTRL_IDX * 4);
    localparam logic [15:0] TAG_MAP_ADDR = 16'(TAG_MAP_IDX * 4);
    localparam logic [15:0] UNK_FWD_ADDR = 16'(UNK_FWD_IDX * 4);
    localparam logic [15:0] MODE_ADDR = 16'(MODE_IDX * 4);

    // Values after reset
    localparam logic [15:0] TAG_MAP_RST = 16'hFA50;
    localparam logic [15:0] UNK_FWD_RST = 16'h0007;
    localparam logic [6:0] LED_CTRL_HI_RST = 7'h04;
    localparam logic [7:0] LED_CTRL_LO_RO = 8'h35;
    localparam logic [1:0] MODE_RST = 2'h2;

    // Field positions
    localparam int unsigned UNK_EN_BIT = 7;
    localparam int unsigned UNK_MASK_MSB = 2;
    localparam int unsigned LED_SEL_HIGH_BIT = 6;
    localparam int unsigned LED_SEL_LOW_BIT = 0;
    localparam int unsigned MODE_RPT_BIT = 0;
    localparam int unsigned MODE_FC_BIT = 1;
    localparam int unsigned MODE_ACTIVE_BIT = 8;
    localparam int unsigned PRIO_W = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic collision;
        logic activity;
        logic [2:0] link_rx;
        logic [2:0] error;
    } rpt_status_t;

    typedef struct packed {
        logic link;
        logic activity;
        logic full_duplex;
        logic collision;
        logic speed_100;
    } port_status_t;

    typedef enum logic [1:0] {
        LED_SEL_00,
        LED_SEL_01,
        LED_SEL_10,
        LED_SEL_11
    } led_sel_t;

endpackage : prio_flood_pkg

/* File: core/led_indicator_mux.sv */
`timescale 1ns/1ps
`default_nettype none

module led_indicator_mux
    import prio_flood_pkg::*;
(
    input wire logic repeater_on,
    input wire led_sel_t sel,
    input wire rpt_status_t rpt,
    input wire port_status_t [1:0] port_st,
    output logic [1:0][3:0] ind
);

    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : g_port
            logic lnk_act;
            logic [3:0] rpt_view;
            // Link lit steadily, blinks off while traffic moves
            assign lnk_act = port_st[p].link & ~port_st[p].activity;
            // Port 1 shows collision and link/rx, port 2 activity and errors
            assign rpt_view = (p == 0) ? {rpt.collision, rpt.link_rx[2], rpt.link_rx[1],
                                          rpt.link_rx[0]}
                                       : {rpt.activity, rpt.error[2], rpt.error[1],
                                          rpt.error[0]};
            always_comb
            begin
                ind[p] = 4'h0;
                if (repeater_on)
                begin
                    if (sel == LED_SEL_00)
                        ind[p] = rpt_view;
                end
                else
                begin
                    case (sel)
                        LED_SEL_00: ind[p] = {1'b0, lnk_act,
                                              port_st[p].full_duplex | port_st[p].collision,
                                              port_st[p].speed_100};
                        LED_SEL_01: ind[p] = {1'b0, lnk_act & port_st[p].speed_100,
                                              lnk_act & ~port_st[p].speed_100,
                                              port_st[p].full_duplex};
                        LED_SEL_10: ind[p] = {port_st[p].activity, port_st[p].link,
                                              port_st[p].full_duplex | port_st[p].collision,
                                              port_st[p].speed_100};
                        default: ind[p] = 4'h0;
                    endcase
                end
            end
        end
    endgenerate

endmodule : led_indicator_mux

`default_nettype wire

/* File: core/switch_priority_flood_led_ctrl.sv */
// Overview of operation
// - tags 7,6 use bits 15-14,13-12; reset 3
// - tags 5,4 use bits 11-10,9-8; reset 2
// - tags 3,2 use bits 7-6,5-4; reset 1
// - tags 1,0 use bits 3-2,1-0; reset 0
// - enable bit 7 sends unknown frames to mask
// - mask bits 2-0: host, port 2, port 1
// - repeater default LEDs show collision, links, activity, errors
// - select bits 15 and 9 pick LED meaning
// - repeater only at 100 half, flow control off
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module switch_priority_flood_led_ctrl
    import prio_flood_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic tag_valid,
    input wire logic [2:0] tag_pcp,
    output logic prio_valid,
    output logic [PRIO_W-1:0] prio,
    input wire logic fwd_req,
    input wire logic fwd_unknown,
    input wire logic [2:0] fwd_ingress,
    input wire logic [2:0] fwd_learned,
    output logic fwd_valid,
    output logic [2:0] fwd_ports,
    input wire logic link_speed_100,
    input wire logic link_half_duplex,
    input wire rpt_status_t rpt_status,
    input wire port_status_t [1:0] port_status,
    output logic repeater_active,
    output logic flow_ctrl_en,
    output logic [3:0] port1_indicator,
    output logic [3:0] port2_indicator
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [ADDR_W-1:0] aw_addr;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] tag_map;
        logic [15:0] unk_fwd;
        logic [6:0] led_hi;
        logic [1:0] mode;
        logic rpt_active;
        logic prio_valid;
        logic [PRIO_W-1:0] prio;
        logic fwd_valid;
        logic [2:0] fwd_ports;
        logic [1:0][3:0] ind;
    } state_t;

    localparam state_t ST_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                  tag_map: TAG_MAP_RST, unk_fwd: UNK_FWD_RST,
                                  led_hi: LED_CTRL_HI_RST, mode: MODE_RST, default: '0};

    state_t st_r;
    state_t st_nxt;
    logic [1:0][3:0] ind_mux;
    led_sel_t led_sel;

    assign led_sel = led_sel_t'({st_r.led_hi[LED_SEL_HIGH_BIT], st_r.led_hi[LED_SEL_LOW_BIT]});

    led_indicator_mux u_led_mux (
        .repeater_on(st_r.rpt_active),
        .sel(led_sel),
        .rpt(rpt_status),
        .port_st(port_status),
        .ind(ind_mux)
    );

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] strb);
        merge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    endfunction : merge

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == LED_CTRL_ADDR) || (a == TAG_MAP_ADDR) || (a == UNK_FWD_ADDR)
                 || (a == MODE_ADDR);
    endfunction : mapped

    always_comb
    begin
        logic [15:0] led_word;
        logic [15:0] rd;
        logic [ADDR_W-1:0] ra;
        logic [15:0] led_new;
        led_word = {st_r.led_hi, 1'b0, LED_CTRL_LO_RO};
        led_new = 16'h0000;
        ra = {araddr[ADDR_W-1:2], 2'b00};
        rd = 16'h0000;
        st_nxt = st_r;

        // Write side: address and data may arrive in either order
        if (awvalid && st_r.awready)
        begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = {awaddr[ADDR_W-1:2], 2'b00};
        end
        if (wvalid && st_r.wready)
        begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = wdata[15:0];
            st_nxt.w_strb = wstrb[1:0];
        end
        if (st_r.bvalid && bready)
            st_nxt.bvalid = 1'b0;
        if (st_nxt.aw_have && st_nxt.w_have && !st_r.bvalid)
        begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = mapped(st_nxt.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            case (st_nxt.aw_addr)
                TAG_MAP_ADDR: st_nxt.tag_map = merge(st_r.tag_map, st_nxt.w_data,
                                                     st_nxt.w_strb);
                // Factory-test bits are stored as written; software keeps them zero
                UNK_FWD_ADDR: st_nxt.unk_fwd = merge(st_r.unk_fwd, st_nxt.w_data,
                                                     st_nxt.w_strb);
                LED_CTRL_ADDR:
                begin
                    // Low byte is read-only, so only the upper seven bits are kept
                    led_new = merge(led_word, st_nxt.w_data, st_nxt.w_strb);
                    st_nxt.led_hi = led_new[15:9];
                end
                MODE_ADDR: st_nxt.mode = st_nxt.w_strb[0] ? st_nxt.w_data[1:0] : st_r.mode;
                default: st_nxt.mode = st_r.mode;
            endcase
        end
        // Ready drops while a half is held or a response is pending
        st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;

        // Read side: one read in flight, answered the cycle after it is taken
        if (st_r.rvalid && rready)
        begin
            st_nxt.rvalid = 1'b0;
            st_nxt.arready = 1'b1;
        end
        if (arvalid && st_r.arready)
        begin
            case (ra)
                TAG_MAP_ADDR: rd = st_r.tag_map;
                UNK_FWD_ADDR: rd = st_r.unk_fwd;
                LED_CTRL_ADDR: rd = led_word;
                MODE_ADDR: rd = {7'h00, st_r.rpt_active, 6'h00, st_r.mode};
                default: rd = 16'h0000;
            endcase
            st_nxt.arready = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = {16'h0000, rd};
            st_nxt.rresp = mapped(ra) ? RESP_OKAY : RESP_SLVERR;
        end

        // Repeater needs 100 Mbit/s half duplex with flow control off
        st_nxt.rpt_active = st_r.mode[MODE_RPT_BIT] && !st_r.mode[MODE_FC_BIT]
                            && link_speed_100 && link_half_duplex;

        st_nxt.prio_valid = tag_valid;
        st_nxt.prio = st_r.tag_map[{tag_pcp, 1'b0} +: PRIO_W];

        st_nxt.fwd_valid = fwd_req;
        if (!fwd_unknown)
            st_nxt.fwd_ports = fwd_learned;
        else if (st_r.unk_fwd[UNK_EN_BIT])
            st_nxt.fwd_ports = st_r.unk_fwd[UNK_MASK_MSB:0];
        else
            st_nxt.fwd_ports = ~fwd_ingress;

        st_nxt.ind = ind_mux;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_r <= ST_RST;
        else
            st_r <= st_nxt;
    end

    assign awready = st_r.awready;
    assign wready = st_r.wready;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign arready = st_r.arready;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign prio_valid = st_r.prio_valid;
    assign prio = st_r.prio;
    assign fwd_valid = st_r.fwd_valid;
    assign fwd_ports = st_r.fwd_ports;
    assign repeater_active = st_r.rpt_active;
    assign flow_ctrl_en = st_r.mode[MODE_FC_BIT];
    assign port1_indicator = st_r.ind[0];
    assign port2_indicator = st_r.ind[1];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence unknown_req_s;
        fwd_req && fwd_unknown;
    endsequence

    sequence flood_enabled_s;
        unknown_req_s ##0 st_r.unk_fwd[UNK_EN_BIT];
    endsequence

    chk_tag_seven_map: assert property (tag_valid && tag_pcp == 3'h7 |=> prio_valid && prio == $past(st_r.tag_map[15:14])) else $error("tag 7 priority wrong");
    chk_tag_five_map: assert property (tag_valid && tag_pcp == 3'h5 |=> prio == $past(st_r.tag_map[11:10])) else $error("tag 5 priority wrong");
    chk_tag_two_map: assert property (tag_valid && tag_pcp == 3'h2 |=> prio == $past(st_r.tag_map[5:4])) else $error("tag 2 priority wrong");
    chk_tag_reset_map: assert property ($rose(aresetn) |-> st_r.tag_map == 16'hFA50 && st_r.unk_fwd[2:0] == 3'h7) else $error("reset map wrong");
    chk_unknown_mask: assert property (flood_enabled_s |=> fwd_valid && fwd_ports == $past(st_r.unk_fwd[2:0])) else $error("unknown frame not sent to mask");
    chk_mask_after_write: assert property ($rose(bvalid) && st_r.aw_addr == UNK_FWD_ADDR && st_r.w_strb[0] |-> st_r.unk_fwd[2:0] == st_r.w_data[2:0]) else $error("mask not stored on write");
    chk_normal_flood: assert property (unknown_req_s ##0 !st_r.unk_fwd[UNK_EN_BIT] |=> fwd_ports == ~$past(fwd_ingress)) else $error("normal flood wrong");
    chk_repeater_gate: assert property (!link_speed_100 || !link_half_duplex || flow_ctrl_en |=> !repeater_active) else $error("repeater active off 100 half");
    chk_repeater_leds: assert property (repeater_active && led_sel == LED_SEL_00 |=> port1_indicator == {$past(rpt_status.collision), $past(rpt_status.link_rx)}) else $error("repeater port 1 LEDs wrong");
    chk_led_sel_off: assert property (led_sel == LED_SEL_11 && $stable(led_sel) |=> port1_indicator == 4'h0 && port2_indicator == 4'h0) else $error("LED select 11 not dark");

endmodule : switch_priority_flood_led_ctrl

`default_nettype wire

/* File: verification/switch_priority_flood_led_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module switch_priority_flood_led_ctrl_bench;
    import prio_flood_pkg::*;

    localparam int LIMIT = 20000;
    logic aclk, aresetn;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, prio, resp;
    logic tag_valid, prio_valid, fwd_req, fwd_unknown, fwd_valid;
    logic [2:0] tag_pcp, fwd_ingress, fwd_learned, fwd_ports;
    logic link_speed_100, link_half_duplex, repeater_active, flow_ctrl_en;
    rpt_status_t rpt_status;
    port_status_t [1:0] port_status;
    logic [3:0] port1_indicator, port2_indicator;
    logic [31:0] rd;
    int n_fail, total_checks, cycles;

    switch_priority_flood_led_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .tag_valid(tag_valid), .tag_pcp(tag_pcp), .prio_valid(prio_valid),
        .prio(prio), .fwd_req(fwd_req), .fwd_unknown(fwd_unknown), .fwd_ingress(fwd_ingress),
        .fwd_learned(fwd_learned), .fwd_valid(fwd_valid), .fwd_ports(fwd_ports),
        .link_speed_100(link_speed_100), .link_half_duplex(link_half_duplex),
        .rpt_status(rpt_status), .port_status(port_status), .repeater_active(repeater_active),
        .flow_ctrl_en(flow_ctrl_en), .port1_indicator(port1_indicator),
        .port2_indicator(port2_indicator));

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task end_of_test;
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Both channels offered together; each released once taken
    task axi_write(input logic [15:0] a, input logic [15:0] d, output logic [1:0] r);
        bit aw_done, w_done;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= {16'h0000, d}; wstrb <= 4'hF;
        wvalid <= 1'b1; bready <= 1'b1;
        aw_done = 0; w_done = 0;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin aw_done = 1; awvalid <= 1'b0; end
            if (!w_done && wready === 1'b1) begin w_done = 1; wvalid <= 1'b0; end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata; r = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task reg_check(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
        axi_read(a, rd, resp);
        chk(rd, exp);
        chk({30'h0, resp}, {30'h0, er});
    endtask : reg_check

    // Back to back lookups of every tag value
    task lookup_all(input logic [15:0] map);
        @(posedge aclk);
        tag_valid <= 1'b1; tag_pcp <= 3'h0;
        for (int p = 1; p <= 8; p++)
        begin
            @(posedge aclk);
            tag_valid <= (p < 8); tag_pcp <= 3'(p);
            #1 chk({29'h0, prio_valid, prio}, {29'h0, 1'b1, map[2*(p-1) +: 2]});
        end
    endtask : lookup_all

    task fwd_check(input logic unk, input logic [2:0] ing, input logic [2:0] lrn,
                   input logic [2:0] exp);
        @(posedge aclk);
        fwd_req <= 1'b1; fwd_unknown <= unk; fwd_ingress <= ing; fwd_learned <= lrn;
        @(posedge aclk);
        fwd_req <= 1'b0;
        #1 chk({28'h0, fwd_valid, fwd_ports}, {28'h0, 1'b1, exp});
    endtask : fwd_check

    task led_check(input rpt_status_t s, input logic [7:0] exp, input logic act);
        @(posedge aclk);
        rpt_status <= s;
        // Mode passes through two register stages, select through one
        repeat (3) @(posedge aclk);
        #1 chk({23'h0, repeater_active, port1_indicator, port2_indicator}, {23'h0, act, exp});
    endtask : led_check

    task test_reset_values;
        reg_check(TAG_MAP_ADDR, 32'h0000FA50, RESP_OKAY);
        reg_check(UNK_FWD_ADDR, 32'h00000007, RESP_OKAY);
        reg_check(LED_CTRL_ADDR, 32'h00000835, RESP_OKAY);
        reg_check(16'h0004, 32'h00000000, RESP_SLVERR);
        axi_write(16'h0004, 16'h1234, resp);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    endtask : test_reset_values

    task test_priority_map;
        lookup_all(16'hFA50);
        axi_write(TAG_MAP_ADDR, 16'h1B6C, resp);
        reg_check(TAG_MAP_ADDR, 32'h00001B6C, RESP_OKAY);
        lookup_all(16'h1B6C);
    endtask : test_priority_map

    task test_unknown_forward;
        fwd_check(1'b1, 3'h1, 3'h2, 3'h6);
        fwd_check(1'b1, 3'h4, 3'h0, 3'h3);
        // Factory field kept at zero on every write
        axi_write(UNK_FWD_ADDR, 16'h0085, resp);
        reg_check(UNK_FWD_ADDR, 32'h00000085, RESP_OKAY);
        fwd_check(1'b1, 3'h1, 3'h2, 3'h5);
        fwd_check(1'b0, 3'h1, 3'h2, 3'h2);
        axi_write(UNK_FWD_ADDR, 16'h0082, resp);
        fwd_check(1'b1, 3'h4, 3'h0, 3'h2);
    endtask : test_unknown_forward

    task test_repeater_leds;
        axi_write(MODE_ADDR, 16'h0001, resp);
        led_check(8'b1_0_101_011, 8'hD3, 1'b1);
        led_check(8'b0_1_010_100, 8'h2C, 1'b1);
        chk({31'h0, flow_ctrl_en}, 32'h0);
        reg_check(MODE_ADDR, 32'h00000101, RESP_OKAY);
        axi_write(LED_CTRL_ADDR, 16'h0A00, resp);
        reg_check(LED_CTRL_ADDR, 32'h00000A35, RESP_OKAY);
        led_check(8'b1_1_111_111, 8'h00, 1'b1);
        axi_write(LED_CTRL_ADDR, 16'h0800, resp);
        link_half_duplex <= 1'b0;
        led_check(8'b1_1_111_111, 8'h00, 1'b0);
        link_half_duplex <= 1'b1;
        axi_write(MODE_ADDR, 16'h0003, resp);
        led_check(8'b1_1_111_111, 8'h00, 1'b0);
    endtask : test_repeater_leds

    // Repeater off: every select code over fixed port status
    task test_normal_leds;
        port_status <= {5'b11010, 5'b10101};
        axi_write(LED_CTRL_ADDR, 16'h0000, resp);
        led_check('0, 8'h72, 1'b0);
        axi_write(LED_CTRL_ADDR, 16'h8000, resp);
        led_check('0, 8'h7E, 1'b0);
        axi_write(LED_CTRL_ADDR, 16'h0200, resp);
        led_check('0, 8'h50, 1'b0);
        axi_write(LED_CTRL_ADDR, 16'h8200, resp);
        led_check('0, 8'h00, 1'b0);
    endtask : test_normal_leds

    initial
    begin
        n_fail = 0; total_checks = 0; cycles = 0;
        aresetn = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0; wvalid = 1'b0;
        bready = 1'b0; araddr = '0; arvalid = 1'b0; rready = 1'b0;
        tag_valid = 1'b0; tag_pcp = '0; fwd_req = 1'b0; fwd_unknown = 1'b0;
        fwd_ingress = '0; fwd_learned = '0; link_speed_100 = 1'b1; link_half_duplex = 1'b1;
        rpt_status = '0; port_status = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset_values();
        test_priority_map();
        test_unknown_forward();
        test_repeater_leds();
        test_normal_leds();
        end_of_test();
    end

endmodule : switch_priority_flood_led_ctrl_bench

`default_nettype wire
